// ===== psw_pkg.sv
// Package: constants and types for the PCI sideband wake control block
package psw_pkg;

  // PCI bus master command codes
  localparam logic [3:0] PSW_CMD_MEM_READ      = 4'h6;
  localparam logic [3:0] PSW_CMD_MEM_WRITE     = 4'h7;
  localparam logic [3:0] PSW_CMD_MEM_READ_MULT = 4'hC;
  localparam logic [3:0] PSW_CMD_MEM_READ_LINE = 4'hE;
  localparam logic [3:0] PSW_CMD_MEM_WRITE_INV = 4'hF;

  // Power management configuration register fields
  localparam int PSW_CFG_WIDTH       = 32;
  localparam int PSW_BIT_WAKE_EN     = 18;
  localparam int PSW_BIT_STYLE_SEL   = 17;
  localparam logic [31:0] PSW_CFG_RST = 32'h0000_0000;

  // Serial EEPROM geometry and word addresses of the loaded fields
  localparam int PSW_EE_BYTES        = 64;
  localparam int PSW_EE_WORDS        = PSW_EE_BYTES / 2;
  localparam int PSW_EE_AW           = 6;
  localparam logic [5:0] PSW_EE_ADR_DEVICE  = 6'h00;
  localparam logic [5:0] PSW_EE_ADR_VENDOR  = 6'h01;
  localparam logic [5:0] PSW_EE_ADR_SUBSYS  = 6'h02;
  localparam logic [5:0] PSW_EE_ADR_SUBVEN  = 6'h03;
  localparam logic [5:0] PSW_EE_ADR_LATGNT  = 6'h04;
  localparam logic [2:0] PSW_EE_NUM_LOADS   = 3'h5;
  localparam logic [2:0] PSW_EE_READ_OP     = 3'h6;

  // Timing
  localparam int PSW_CLK_HZ          = 10_000_000;
  localparam int PSW_CLK_NS          = 100;
  localparam int PSW_WAKE_PULSE_MS   = 50;
  localparam int PSW_WAKE_PULSE_CYC  =
    PSW_WAKE_PULSE_MS * (PSW_CLK_HZ / 1000);
  localparam int PSW_EE_CLK_DIV      = 4;
  localparam logic [7:0] PSW_LOAD_SETTLE_CYC = 8'h04;

  // Master request from the datapath
  typedef struct packed {
    logic        valid;
    logic [3:0]  cmd;
    logic [31:0] data;
  } psw_mreq_t;

  // Identification and latency values loaded from EEPROM
  typedef struct packed {
    logic [15:0] device_id;
    logic [15:0] vendor_id;
    logic [15:0] subsys_id;
    logic [15:0] subsys_vendor_id;
    logic [7:0]  max_lat;
    logic [7:0]  min_gnt;
  } psw_ids_t;

  // Open drain / tristate pin group: enable low while driving
  typedef struct packed {
    logic o;
    logic oe_n;
  } psw_pin_t;

  typedef enum logic [2:0] {
    PSW_LD_IDLE  = 3'b000,
    PSW_LD_SEL   = 3'b001,
    PSW_LD_SHIFT = 3'b011,
    PSW_LD_STORE = 3'b010,
    PSW_LD_DONE  = 3'b110
  } psw_ld_state_t;

endpackage

// ===== psw_ee_loader.sv
// Serial EEPROM autoload of identification and latency values
`timescale 1ns/100ps
module psw_ee_loader
  import psw_pkg::*;
#(
  parameter int DIV = PSW_EE_CLK_DIV
)
(
  input  wire logic     mclk,
  input  wire logic     arst_n,
  input  wire logic     ee_do,
  output logic          ee_cs,
  output logic          ee_sk,
  output logic          ee_di,
  output psw_ids_t      ids,
  output logic          load_done
);

  psw_ld_state_t state_r;
  logic [7:0]    div_r;
  logic [5:0]    bit_r;
  logic [2:0]    idx_r;
  logic [26:0]   sh_r;
  logic [15:0]   rd_r;
  logic          do_s1_r;
  logic          do_s2_r;
  logic          tick;
  logic [5:0]    adr;

  assign tick = (div_r == 8'(DIV - 1));

  always_comb
  begin
    case (idx_r)
      3'h0:    adr = PSW_EE_ADR_DEVICE;
      3'h1:    adr = PSW_EE_ADR_VENDOR;
      3'h2:    adr = PSW_EE_ADR_SUBSYS;
      3'h3:    adr = PSW_EE_ADR_SUBVEN;
      default: adr = PSW_EE_ADR_LATGNT;
    endcase
  end

  // Data-out synchroniser
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      do_s1_r <= 1'b0;
      do_s2_r <= 1'b0;
    end
    else
    begin
      do_s1_r <= ee_do;
      do_s2_r <= do_s1_r;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      div_r <= 8'h00;
    else if (tick)
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;
  end

  // Read sequence: start+opcode, address, then 16 data bits
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r   <= PSW_LD_IDLE;
      bit_r     <= 6'h00;
      idx_r     <= 3'h0;
      sh_r      <= '0;
      rd_r      <= 16'h0000;
      ee_cs     <= 1'b0;
      ee_sk     <= 1'b0;
      ee_di     <= 1'b0;
      ids       <= '0;
      load_done <= 1'b0;
    end
    else if (tick)
    begin
      case (state_r)
        PSW_LD_IDLE:
        begin
          state_r <= PSW_LD_SEL;
        end
        PSW_LD_SEL:
        begin
          ee_cs   <= 1'b1;
          sh_r    <= {1'b1, PSW_EE_READ_OP[1:0], adr, 18'h00000};
          bit_r   <= 6'h00;
          state_r <= PSW_LD_SHIFT;
        end
        PSW_LD_SHIFT:
        begin
          ee_sk <= ~ee_sk;
          if (!ee_sk)
          begin
            ee_di <= sh_r[26];
            sh_r  <= {sh_r[25:0], 1'b0};
          end
          else
          begin
            if (bit_r >= 6'h09)
              rd_r <= {rd_r[14:0], do_s2_r};
            if (bit_r == 6'h18)
              state_r <= PSW_LD_STORE;
            bit_r <= bit_r + 6'h01;
          end
        end
        PSW_LD_STORE:
        begin
          ee_cs <= 1'b0;
          ee_sk <= 1'b0;
          case (idx_r)
            3'h0:    ids.device_id        <= rd_r;
            3'h1:    ids.vendor_id        <= rd_r;
            3'h2:    ids.subsys_id        <= rd_r;
            3'h3:    ids.subsys_vendor_id <= rd_r;
            default: {ids.max_lat, ids.min_gnt} <= rd_r;
          endcase
          idx_r <= idx_r + 3'h1;
          if (idx_r == PSW_EE_NUM_LOADS - 3'h1)
            state_r <= PSW_LD_DONE;
          else
            state_r <= PSW_LD_SEL;
        end
        PSW_LD_DONE:
        begin
          load_done <= 1'b1;
        end
        default:
        begin
          state_r <= PSW_LD_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== psw_top.sv
// PCI sideband control: interrupt, request, commands, wake and autoload
`timescale 1ns/100ps
// Summary of operation
// - The open-drain interrupt pin is pulled low while any enabled event is pending.
// - During reset the interrupt, request and wake pins are released; other outputs take their reset values.
// - All bus inputs are sampled on the rising edge of the bus clock.
// - Logic is fully static, so a stopped clock up to 33 MHz is tolerated.
// - Bus request is raised when ownership is needed and a grant accepts it.
// - Only memory read, read line, read multiple, write and write invalidate are issued.
// - Master data can be byte-swapped for big-endian or passed little-endian.
// - The wake output is an open-drain, active-low signal.
// - Setting bit 18 of the power config register enters wake mode.
// - In wake mode a valid wake-up frame asserts the wake output.
// - In wake mode bit 17 selects the first wake style when 1, the other when 0.
// - After reset release ids and latency values are loaded from the 64-byte EEPROM.
module psw_top
  import psw_pkg::*;
#(
  parameter int WAKE_PULSE_CYC = PSW_WAKE_PULSE_CYC
)
(
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [7:0]   irq_events,
  input  wire logic [7:0]   irq_enable,
  input  wire logic         gnt_n,
  input  wire logic         need_bus,
  input  wire psw_mreq_t    mreq,
  input  wire logic         big_endian,
  input  wire logic         cfg_we,
  input  wire logic [31:0]  cfg_wdata,
  input  wire logic         wake_frame,
  input  wire logic         ee_do,
  output psw_pin_t          inta_pin,
  output psw_pin_t          req_pin,
  output psw_pin_t          pme_pin,
  output logic              mst_valid,
  output logic [3:0]        mst_cmd,
  output logic [31:0]       mst_data,
  output logic              bus_owned,
  output logic              cmd_rejected,
  output logic [31:0]       cfg_rdata,
  output psw_ids_t          ids,
  output logic              ids_valid,
  output logic              ee_cs,
  output logic              ee_sk,
  output logic              ee_di
);

  logic [1:0]  gnt_sync_r;
  logic [31:0] pm_cfg_r;
  logic        req_r;
  logic        pme_act_r;
  logic [31:0] pme_cnt_r;
  logic        wake_mode;
  logic        style_first;
  logic        cmd_ok;
  logic [31:0] swapped;
  logic [7:0]  irq_pend;
  logic [31:0] mst_data_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Fully static: a stopped clock only holds state
  // Grant synchroniser
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      gnt_sync_r <= 2'b11;
    else
      gnt_sync_r <= {gnt_sync_r[0], gnt_n};
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request, open drain
  genvar ei;
  generate
    for (ei = 0; ei < 8; ei++)
    begin : g_irq
      assign irq_pend[ei] = irq_events[ei] & irq_enable[ei];
    end
  endgenerate

  always_comb
  begin
    inta_pin.o    = 1'b0;
    inta_pin.oe_n = ~(|irq_pend);
    if (!arst_n)
      inta_pin.oe_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus request and grant
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      req_r <= 1'b0;
    else
      req_r <= need_bus;
  end

  always_comb
  begin
    req_pin.o    = ~req_r;
    req_pin.oe_n = 1'b0;
    if (!arst_n)
      req_pin.oe_n = 1'b1;
  end

  assign bus_owned = req_r & ~gnt_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // Master command filter and byte ordering
  always_comb
  begin
    case (mreq.cmd)
      PSW_CMD_MEM_READ,
      PSW_CMD_MEM_READ_LINE,
      PSW_CMD_MEM_READ_MULT,
      PSW_CMD_MEM_WRITE,
      PSW_CMD_MEM_WRITE_INV: cmd_ok = 1'b1;
      default:               cmd_ok = 1'b0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_swap
      assign swapped[gi*8 +: 8] = mreq.data[(3-gi)*8 +: 8];
    end
  endgenerate

  assign mst_data_nxt = big_endian ? swapped : mreq.data;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mst_valid    <= 1'b0;
      mst_cmd      <= PSW_CMD_MEM_READ;
      mst_data     <= 32'h0000_0000;
      cmd_rejected <= 1'b0;
    end
    else
    begin
      mst_valid    <= mreq.valid & cmd_ok & bus_owned;
      cmd_rejected <= mreq.valid & ~cmd_ok;
      if (mreq.valid & cmd_ok)
      begin
        mst_cmd  <= mreq.cmd;
        mst_data <= mst_data_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power management configuration register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      pm_cfg_r <= PSW_CFG_RST;
    else if (cfg_we)
      pm_cfg_r <= cfg_wdata;
  end

  assign cfg_rdata   = pm_cfg_r;
  assign wake_mode   = pm_cfg_r[PSW_BIT_WAKE_EN];
  assign style_first = pm_cfg_r[PSW_BIT_STYLE_SEL];

  ////////////////////////////////////////////////////////////////////////
  // Wake event: timed pulse or held level
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pme_act_r <= 1'b0;
      pme_cnt_r <= 32'h0000_0000;
    end
    else if (wake_frame && wake_mode)
    begin
      pme_act_r <= 1'b1;
      pme_cnt_r <= 32'(WAKE_PULSE_CYC - 1);
    end
    else if (!wake_mode)
    begin
      pme_act_r <= 1'b0;
      pme_cnt_r <= 32'h0000_0000;
    end
    else if (pme_act_r && style_first)
    begin
      if (pme_cnt_r == 32'h0000_0000)
        pme_act_r <= 1'b0;
      else
        pme_cnt_r <= pme_cnt_r - 32'h0000_0001;
    end
  end

  always_comb
  begin
    pme_pin.o    = 1'b0;
    pme_pin.oe_n = ~pme_act_r;
    if (!arst_n)
      pme_pin.oe_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // EEPROM autoload
  psw_ee_loader u_loader
  (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .ee_do     (ee_do),
    .ee_cs     (ee_cs),
    .ee_sk     (ee_sk),
    .ee_di     (ee_di),
    .ids       (ids),
    .load_done (ids_valid)
  );

endmodule

// ===== psw_checker.sv
// Port checker for the sideband wake block
`timescale 1ns/100ps
module psw_checker
  import psw_pkg::*;
#(
  parameter int WAKE_PULSE_CYC = PSW_WAKE_PULSE_CYC
)
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [7:0]  irq_events,
  input wire logic [7:0]  irq_enable,
  input wire logic        gnt_n,
  input wire logic        need_bus,
  input wire psw_mreq_t   mreq,
  input wire logic        big_endian,
  input wire logic        cfg_we,
  input wire logic        wake_frame,
  input wire psw_pin_t    inta_pin,
  input wire psw_pin_t    req_pin,
  input wire psw_pin_t    pme_pin,
  input wire logic        mst_valid,
  input wire logic [3:0]  mst_cmd,
  input wire logic [31:0] mst_data,
  input wire logic        bus_owned,
  input wire logic        cmd_rejected,
  input wire logic [31:0] cfg_rdata,
  input wire psw_ids_t    ids,
  input wire logic        ids_valid
);
  logic [31:0] swp;
  logic        legal;
  int          lo_r;
  assign swp = {mreq.data[7:0], mreq.data[15:8],
                mreq.data[23:16], mreq.data[31:24]};
  assign legal = mreq.cmd inside {PSW_CMD_MEM_READ, PSW_CMD_MEM_WRITE,
    PSW_CMD_MEM_READ_MULT, PSW_CMD_MEM_READ_LINE, PSW_CMD_MEM_WRITE_INV};
  // Cycles the wake pin has been low
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      lo_r <= 0;
    else
      lo_r <= pme_pin.oe_n ? 0 : lo_r + 1;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  a_irq_pull_low: assert property (
    inta_pin.oe_n == !(|(irq_events & irq_enable))) else $error("irq");
  a_req_follow: assert property (
    req_pin.o == !$past(need_bus)) else $error("req");
  a_grant_owned: assert property (
    bus_owned == (!req_pin.o && !$past(gnt_n, 2))) else $error("own");
  a_issue_legal: assert property (
    mst_valid |-> $past(mreq.valid && legal && bus_owned) &&
    mst_cmd == $past(mreq.cmd) &&
    mst_data == $past(big_endian ? swp : mreq.data)) else $error("mst");
  a_issue_taken: assert property (
    mreq.valid && legal && bus_owned |=> mst_valid) else $error("take");
  a_cmd_refused: assert property (
    mreq.valid && !legal |=> cmd_rejected && !mst_valid) else $error("rej");
  a_wake_frame: assert property (
    wake_frame && cfg_rdata[18] && !cfg_we |=> !pme_pin.oe_n && !pme_pin.o)
    else $error("wake");
  a_wake_off: assert property (
    !cfg_rdata[18] [*2] |-> pme_pin.oe_n) else $error("off");
  a_pulse_len: assert property (
    cfg_rdata[17] |-> lo_r <= WAKE_PULSE_CYC + 1) else $error("pulse");
  a_level_hold: assert property (
    cfg_rdata[18] && !cfg_rdata[17] && !pme_pin.oe_n && !cfg_we
    |=> !pme_pin.oe_n) else $error("level");
  a_ids_hold: assert property (
    ids_valid |=> ids_valid && $stable(ids)) else $error("ids");
  c_issue: cover property (mst_valid);
  c_reject: cover property (cmd_rejected);
  c_wake: cover property ($fell(pme_pin.oe_n));
endmodule
bind psw_top psw_checker #(.WAKE_PULSE_CYC(WAKE_PULSE_CYC)) u_psw_checker (.*);

// ===== psw_host_model.sv
// Host, arbiter and serial EEPROM model with wake line pull-up
`timescale 1ns/100ps
module psw_host_model
  import psw_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire psw_pin_t   req_pin,
  input  wire psw_pin_t   pme_pin,
  input  wire logic [3:0] gnt_dly,
  input  wire logic       ee_cs,
  input  wire logic       ee_sk,
  input  wire logic       ee_di,
  output logic            gnt_n,
  output logic            pme_wire,
  output logic            ee_do
);
  logic [3:0]  wait_r;
  logic        sk_q_r;
  logic [4:0]  ee_cnt_r;
  logic [8:0]  ee_cmd_r;
  logic [15:0] rom_word;
  // Pulled-up open-drain wake line
  assign pme_wire = pme_pin.oe_n ? 1'b1 : pme_pin.o;
  // Grant after the set delay, drop with the request
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      gnt_n  <= 1'b1;
      wait_r <= 4'h0;
    end
    else if (!req_pin.oe_n && !req_pin.o)
    begin
      if (wait_r == gnt_dly)
        gnt_n <= 1'b0;
      else
        wait_r <= wait_r + 4'h1;
    end
    else
    begin
      gnt_n  <= 1'b1;
      wait_r <= 4'h0;
    end
  ////////////////////////////////////////////////////////////////////////
  // EEPROM: word at each address is {C, address, inverted address}
  assign rom_word = {4'hC, ee_cmd_r[5:0], ~ee_cmd_r[5:0]};
  // Data bits only after start, read opcode and six address bits
  assign ee_do = (ee_cnt_r >= 5'h0A && ee_cmd_r[8:6] == 3'b110) ?
                 rom_word[5'h19 - ee_cnt_r] : 1'b0;
  // Count clock rises while selected, shift in the command
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      sk_q_r   <= 1'b0;
      ee_cnt_r <= 5'h00;
      ee_cmd_r <= 9'h000;
    end
    else
    begin
      sk_q_r <= ee_sk;
      if (!ee_cs)
        ee_cnt_r <= 5'h00;
      else if (ee_sk && !sk_q_r)
      begin
        if (ee_cnt_r < 5'h09)
          ee_cmd_r <= {ee_cmd_r[7:0], ee_di};
        ee_cnt_r <= ee_cnt_r + 5'h01;
      end
    end
endmodule

// ===== psw_top_tb.sv
// Testbench of the sideband wake block
`timescale 1ns/100ps
module psw_top_tb
  import psw_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  irq_events = 8'hFF;
  logic [7:0]  irq_enable = 8'hFF;
  logic        need_bus = 1'b0;
  logic        big_endian = 1'b0;
  logic        cfg_we = 1'b0;
  logic        wake_frame = 1'b0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [3:0]  gnt_dly = 4'h3;
  psw_mreq_t   mreq = '0;
  wire         ee_do;
  logic        gnt_n, mst_valid, bus_owned, cmd_rejected, ids_valid;
  logic        ee_cs, ee_sk, ee_di, pme_wire;
  logic [3:0]  mst_cmd;
  logic [31:0] mst_data, cfg_rdata;
  psw_pin_t    inta_pin, req_pin, pme_pin;
  psw_ids_t    ids;
  int          fails = 0;
  int          num_checks = 0;
  psw_top #(.WAKE_PULSE_CYC(20)) u_psw_top (.*);
  psw_host_model u_psw_host_model (.*);
  always #50 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cfg_wr(input logic [31:0] v);
    cfg_we = 1'b1;
    cfg_wdata = v;
    cyc;
    cfg_we = 1'b0;
    chk(cfg_rdata, v);
  endtask
  task automatic pulse_frame;
    wake_frame = 1'b1;
    cyc;
    wake_frame = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ee_word(input logic [5:0] a);
    return {4'hC, a, ~a};
  endfunction
  task automatic t_autoload;
    int       n = 0;
    psw_ids_t exp_ids;
    exp_ids = {ee_word(PSW_EE_ADR_DEVICE), ee_word(PSW_EE_ADR_VENDOR),
               ee_word(PSW_EE_ADR_SUBSYS), ee_word(PSW_EE_ADR_SUBVEN),
               ee_word(PSW_EE_ADR_LATGNT)};
    while (!ids_valid && n < 5000)
    begin
      cyc;
      n++;
    end
    chk(ids_valid, 1'b1);
    chk(ids, exp_ids);
  endtask
  task automatic t_irq;
    for (int i = 0; i < 8; i++)
    begin
      irq_enable = 8'h01 << i;
      irq_events = 8'h01 << i;
      #1;
      chk(inta_pin.oe_n, 1'b0);
      irq_events = ~irq_enable;
      #1;
      chk(inta_pin.oe_n, 1'b1);
    end
    irq_events = 8'h00;
  endtask
  task automatic t_master;
    logic [3:0]  cmds [5] = '{PSW_CMD_MEM_READ, PSW_CMD_MEM_READ_LINE,
      PSW_CMD_MEM_READ_MULT, PSW_CMD_MEM_WRITE, PSW_CMD_MEM_WRITE_INV};
    logic [31:0] d;
    int          n = 0;
    need_bus = 1'b1;
    cyc;
    chk(req_pin.o, 1'b0);
    while (!bus_owned && n < 20)
    begin
      cyc;
      n++;
    end
    chk(bus_owned, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      d = 32'hA1B2_C3D4 + i;
      big_endian = i[0];
      mreq = '{1'b1, cmds[i], d};
      cyc;
      chk(mst_valid, 1'b1);
      chk(mst_cmd, cmds[i]);
      chk(mst_data, i[0] ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d);
    end
    mreq.cmd = 4'h2;
    cyc;
    chk({cmd_rejected, mst_valid}, 2'b10);
    mreq = '0;
    need_bus = 1'b0;
    cyc;
    cyc;
    chk(req_pin.o, 1'b1);
  endtask
  task automatic t_wake;
    int n = 0;
    chk(cfg_rdata, PSW_CFG_RST);
    pulse_frame;
    cyc;
    chk(pme_wire, 1'b1);
    cfg_wr(32'h0006_0000);
    pulse_frame;
    chk(pme_wire, 1'b0);
    while (!pme_wire && n < 100)
    begin
      cyc;
      n++;
    end
    chk(n >= 20 && n <= 21, 1'b1);
    cfg_wr(32'h0004_0000);
    pulse_frame;
    repeat (30) cyc;
    chk(pme_wire, 1'b0);
    cfg_wr(32'h0000_0000);
    cyc;
    chk(pme_wire, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) cyc;
    chk({inta_pin.oe_n, req_pin.oe_n, pme_pin.oe_n}, 3'b111);
    arst_n = 1'b1;
    t_autoload;
    t_irq;
    t_master;
    t_wake;
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    tally_and_finish;
  end
endmodule
